// [rtl/nfcs_host.sv]
// Purpose: host side controller issuing flash command sequences on pins
// Assumes: one clock mclk at 125 MHz, synchronous active high rst
// Notes: each bus write is one write strobe pulse; chip select stays low for the whole sequence
// What this block does
// - reset command returns flash to array read
// - identification mode held until reset written
// - timeout flag seen, host writes reset; this block only returns the status in rspData, the user issues NFCS_OP_RESET
// - two unlocks plus identification command enter it
// - program is four writes, then internal timer
// - fast program mode uses two-cycle sequence
// - chip erase is six write cycles
// - sector erase six cycles, sector in last
// - resume continues erase, repeated resumes ignored
// - unlock addresses and command codes as listed
`timescale 1ns/1ps
module nfcs_host
  import nfcs_pkg::*;
#(
  parameter int POWERUP_CYC = 5000 // power-up lockout wait in cycles
) (
  input wire logic mclk, // clock
  input wire logic rst, // synchronous reset, active high
  input wire logic reqValid, // user request strobe
  input wire nfcs_op_t reqOp, // requested operation
  input wire logic [ADDR_W-1:0] reqAddr, // target address or sector
  input wire logic [DATA_W-1:0] reqData, // program data or raw command
  input wire logic byteMode, // width select, high for byte mode
  output logic reqReady, // idle and accepting a request
  output logic rspValid, // read or write sequence done, one cycle
  output logic [DATA_W-1:0] rspData, // data read from the flash
  output logic [ADDR_W-1:0] flashAddr, // flash address pins
  output logic [DATA_W-1:0] flashDqOut, // flash data drive value
  output logic flashDqOe, // data pins driven while high
  input wire logic [DATA_W-1:0] flashDqIn, // flash data pins in
  output logic flashCeN, // chip select, active low
  output logic flashWeN, // write strobe, active low
  output logic flashOeN, // output strobe, active low
  output logic flashByteN // width select pin, low for byte
);
  // elaboration check: the lockout counter needs at least one cycle
  if (POWERUP_CYC < 1) $error("POWERUP_CYC must be at least one");

  typedef enum {ST_POWER, ST_IDLE, ST_SETUP, ST_PULSE, ST_HOLD, ST_READ} nfcs_state_t;
  nfcs_state_t state_reg, state_next;
  logic [2:0] step_reg, step_next;
  logic [2:0] steps_reg, steps_next;
  nfcs_op_t op_reg, op_next;
  logic [ADDR_W-1:0] addr_reg, addr_next;
  logic [DATA_W-1:0] data_reg, data_next;
  logic [ADDR_W-1:0] flashAddr_next;
  logic [DATA_W-1:0] flashDqOut_next;
  logic [DATA_W-1:0] rspData_next;
  logic [31:0] cnt_reg, cnt_next;
  logic rspValid_reg, rspValid_next;
  logic byteMode_reg;
  logic [DATA_W-1:0] dqSync1_reg, dqSync2_reg;
  // all checks below run on mclk and rest while reset is high
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);

  // width select follows the user while idle, held steady through each operation
  always_ff @(posedge mclk) begin
    if (rst) byteMode_reg <= 1'b0;
    else if (state_reg == ST_IDLE) byteMode_reg <= byteMode;
  end

  // data pins come from another timing domain, two flops before use
  always_ff @(posedge mclk) begin
    dqSync1_reg <= flashDqIn;
    dqSync2_reg <= dqSync1_reg;
  end

  // address and data of one bus write within the active sequence
  function automatic logic [ADDR_W+7:0] seqWord(input nfcs_op_t op, input logic [2:0] idx,
      input logic bm, input logic [ADDR_W-1:0] ad, input logic [DATA_W-1:0] dt);
    logic [ADDR_W-1:0] u1;
    logic [ADDR_W-1:0] u2;
    logic [ADDR_W+7:0] w;
    u1 = bm ? UNLOCK1_BYTE : UNLOCK1_WORD;
    u2 = bm ? UNLOCK2_BYTE : UNLOCK2_WORD;
    w = {ad, dt[7:0]};
    if (idx == 3'd0 && op != NFCS_OP_RESET && op != NFCS_OP_SUSPEND &&
        op != NFCS_OP_RESUME && op != NFCS_OP_FAST_PROGRAM &&
        op != NFCS_OP_FAST_EXIT && op != NFCS_OP_WRITE_RAW) w = {u1, DATA_UNLOCK1};
    else if (idx == 3'd1 && op != NFCS_OP_FAST_PROGRAM && op != NFCS_OP_FAST_EXIT)
      w = {u2, DATA_UNLOCK2};
    else if (idx == 3'd3 && (op == NFCS_OP_CHIP_ERASE || op == NFCS_OP_SECTOR_ERASE))
      w = {u1, DATA_UNLOCK1};
    else if (idx == 3'd4) w = {u2, DATA_UNLOCK2};
    else begin
      unique case (op)
        NFCS_OP_RESET: w = {ad, CMD_RESET};
        NFCS_OP_SUSPEND: w = {ad, CMD_SUSPEND};
        NFCS_OP_RESUME: w = {ad, CMD_RESUME};
        NFCS_OP_IDENT: w = {u1, CMD_IDENT};
        NFCS_OP_FAST_ENTER: w = {u1, CMD_FAST_ENTER};
        NFCS_OP_PROGRAM: w = (idx == 3'd2) ? {u1, CMD_PROGRAM} : {ad, dt[7:0]};
        NFCS_OP_FAST_PROGRAM: w = (idx == 3'd0) ? {ad, CMD_PROGRAM} : {ad, dt[7:0]};
        NFCS_OP_FAST_EXIT: w = (idx == 3'd0) ? {ad, CMD_FAST_EXIT1} : {ad, CMD_FAST_EXIT2};
        NFCS_OP_CHIP_ERASE: w = {u1, (idx == 3'd2) ? CMD_ERASE_SETUP : CMD_CHIP_ERASE};
        NFCS_OP_SECTOR_ERASE: w = (idx == 3'd2) ? {u1, CMD_ERASE_SETUP} :
            {ad[SECT_HI:SECT_LO], {SECT_LO{1'b0}}, CMD_SECTOR_ERASE};
        default: w = {ad, dt[7:0]};
      endcase
    end
    return w;
  endfunction

  // count of bus writes per operation
  function automatic logic [2:0] seqLen(input nfcs_op_t op);
    unique case (op)
      NFCS_OP_PROGRAM: return 3'd4;
      NFCS_OP_CHIP_ERASE, NFCS_OP_SECTOR_ERASE: return 3'd6;
      NFCS_OP_IDENT, NFCS_OP_FAST_ENTER: return 3'd3;
      NFCS_OP_FAST_PROGRAM, NFCS_OP_FAST_EXIT: return 3'd2;
      default: return 3'd1;
    endcase
  endfunction

  // sequencer next state: one write per setup, pulse, hold pass
  always_comb begin
    logic [ADDR_W+7:0] w;
    w = seqWord(op_reg, step_reg, byteMode_reg, addr_reg, data_reg);
    state_next = state_reg;
    step_next = step_reg;
    steps_next = steps_reg;
    op_next = op_reg;
    addr_next = addr_reg;
    data_next = data_reg;
    cnt_next = (cnt_reg == 32'd0) ? 32'd0 : cnt_reg - 32'd1;
    rspValid_next = 1'b0;
    rspData_next = rspData;
    flashAddr_next = flashAddr;
    flashDqOut_next = flashDqOut;
    unique case (state_reg)
      ST_POWER: begin
        if (cnt_reg == 32'd0) state_next = ST_IDLE;
      end
      ST_IDLE: begin
        if (reqValid) begin
          op_next = reqOp;
          addr_next = reqAddr;
          data_next = reqData;
          step_next = 3'd0;
          steps_next = seqLen(reqOp);
          flashAddr_next = reqAddr;
          state_next = (reqOp == NFCS_OP_READ) ? ST_READ : ST_SETUP;
          cnt_next = (reqOp == NFCS_OP_READ) ? 32'(READ_CYC) : 32'(SETUP_CYC);
        end
      end
      ST_SETUP: begin
        // address settles before the write strobe falls so that later fall latches it
        flashAddr_next = w[ADDR_W+7:8];
        flashDqOut_next = {8'h00, w[7:0]};
        if (op_reg == NFCS_OP_WRITE_RAW || ((op_reg == NFCS_OP_PROGRAM ||
            op_reg == NFCS_OP_FAST_PROGRAM) && step_reg == steps_reg - 3'd1))
          flashDqOut_next = byteMode_reg ? {8'h00, data_reg[7:0]} : data_reg;
        if (cnt_reg == 32'd0) begin
          state_next = ST_PULSE;
          cnt_next = 32'(PULSE_CYC);
        end
      end
      ST_PULSE: begin
        if (cnt_reg == 32'd0) begin
          state_next = ST_HOLD;
          cnt_next = 32'(SETUP_CYC);
        end
      end
      ST_HOLD: begin
        if (cnt_reg == 32'd0) begin
          if (step_reg == steps_reg - 3'd1) begin
            state_next = ST_IDLE;
            rspValid_next = 1'b1;
          end else begin
            step_next = step_reg + 3'd1;
            state_next = ST_SETUP;
            cnt_next = 32'(SETUP_CYC);
          end
        end
      end
      ST_READ: begin
        if (cnt_reg == 32'd0) begin
          rspData_next = dqSync2_reg; // status bits visible here
          rspValid_next = 1'b1;
          state_next = ST_IDLE;
        end
      end
    endcase
  end

  // sequencer registers
  always_ff @(posedge mclk) begin
    if (rst) begin
      state_reg <= ST_POWER;
      step_reg <= 3'd0;
      steps_reg <= 3'd1;
      op_reg <= NFCS_OP_READ;
      addr_reg <= '0;
      data_reg <= '0;
      cnt_reg <= 32'(POWERUP_CYC);
      rspValid_reg <= 1'b0;
      rspData <= '0;
      flashAddr <= '0;
      flashDqOut <= '0;
    end else begin
      state_reg <= state_next;
      step_reg <= step_next;
      steps_reg <= steps_next;
      op_reg <= op_next;
      addr_reg <= addr_next;
      data_reg <= data_next;
      cnt_reg <= cnt_next;
      rspValid_reg <= rspValid_next;
      rspData <= rspData_next;
      flashAddr <= flashAddr_next;
      flashDqOut <= flashDqOut_next;
    end
  end

  // strobes: chip select spans the whole write, write strobe only the pulse
  assign reqReady = (state_reg == ST_IDLE);
  assign rspValid = rspValid_reg;
  assign flashCeN = (state_reg == ST_POWER || state_reg == ST_IDLE);
  assign flashWeN = !(state_reg == ST_PULSE);
  assign flashOeN = !(state_reg == ST_READ);
  assign flashDqOe = (state_reg == ST_SETUP || state_reg == ST_PULSE || state_reg == ST_HOLD);
  assign flashByteN = !byteMode_reg;

  // write strobe pulse lasts exactly the pulse count plus one
  sequence s_we_low;
    !flashWeN [*6] ##1 flashWeN;
  endsequence
  property p_we_width;
    $fell(flashWeN) |-> s_we_low;
  endproperty
  a_we_width: assert property (p_we_width) else $error("write pulse width wrong");
  // chip select, address and data outlast the strobe rise, no race at the latch
  property p_we_hold;
    $rose(flashWeN) |-> !flashCeN && flashDqOe && $stable(flashAddr) && $stable(flashDqOut);
  endproperty
  a_we_hold: assert property (p_we_hold) else $error("write hold lost");
  // no write strobe during power-up lockout
  property p_powerup;
    (state_reg == ST_POWER) |-> flashWeN && reqReady == 1'b0;
  endproperty
  a_powerup: assert property (p_powerup) else $error("write during power-up");
  // reset command is one write carrying F0
  property p_reset_code;
    (!flashWeN && op_reg == NFCS_OP_RESET) |-> flashDqOut[7:0] == CMD_RESET;
  endproperty
  a_reset_code: assert property (p_reset_code) else $error("reset code wrong");
  // first unlock write carries AA
  property p_unlock1;
    (!flashWeN && step_reg == 3'd0 && op_reg == NFCS_OP_PROGRAM) |->
      flashDqOut[7:0] == DATA_UNLOCK1 &&
      flashAddr == (byteMode_reg ? UNLOCK1_BYTE : UNLOCK1_WORD);
  endproperty
  a_unlock1: assert property (p_unlock1) else $error("unlock write wrong");
  // program third write is program setup command
  property p_prog_setup;
    (!flashWeN && step_reg == 3'd2 && op_reg == NFCS_OP_PROGRAM) |->
      flashDqOut[7:0] == CMD_PROGRAM;
  endproperty
  a_prog_setup: assert property (p_prog_setup) else $error("program setup wrong");
  // sixth erase write carries the erase command
  property p_erase_last;
    (!flashWeN && step_reg == 3'd5 && op_reg == NFCS_OP_CHIP_ERASE) |->
      flashDqOut[7:0] == CMD_CHIP_ERASE;
  endproperty
  a_erase_last: assert property (p_erase_last) else $error("chip erase code wrong");
  // data pins driven throughout a write strobe
  property p_dq_drive;
    !flashWeN |-> flashDqOe && !flashCeN && flashOeN;
  endproperty
  a_dq_drive: assert property (p_dq_drive) else $error("bus not driven in write");
  // width pin steady during a write
  property p_width;
    !flashWeN |-> $stable(flashByteN);
  endproperty
  a_width: assert property (p_width) else $error("width pin moved in write");
endmodule

// [rtl/nfcs_pkg.sv]
// Purpose: constants for the NOR flash command sequencer host controller
// Assumes: 16-bit word mode or byte mode selected by the width select pin
// Notes: command codes and unlock addresses of the flash command set
package nfcs_pkg;
  localparam int ADDR_W = 20;
  localparam int DATA_W = 16;
  // unlock addresses, word mode then byte mode
  localparam logic [19:0] UNLOCK1_WORD = 20'h00555;
  localparam logic [19:0] UNLOCK2_WORD = 20'h002AA;
  localparam logic [19:0] UNLOCK1_BYTE = 20'h00AAA;
  localparam logic [19:0] UNLOCK2_BYTE = 20'h00555;
  localparam logic [7:0] DATA_UNLOCK1 = 8'hAA;
  localparam logic [7:0] DATA_UNLOCK2 = 8'h55;
  localparam logic [7:0] CMD_PROGRAM = 8'hA0;
  localparam logic [7:0] CMD_IDENT = 8'h90;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h80;
  localparam logic [7:0] CMD_CHIP_ERASE = 8'h10;
  localparam logic [7:0] CMD_SECTOR_ERASE = 8'h30;
  localparam logic [7:0] CMD_SUSPEND = 8'hB0;
  localparam logic [7:0] CMD_RESUME = 8'h30;
  localparam logic [7:0] CMD_RESET = 8'hF0;
  localparam logic [7:0] CMD_FAST_ENTER = 8'h20;
  localparam logic [7:0] CMD_FAST_EXIT1 = 8'h90;
  localparam logic [7:0] CMD_FAST_EXIT2 = 8'h00;
  // sector select field of the address
  localparam int SECT_HI = 19;
  localparam int SECT_LO = 12;
  // status bit positions on the data bus
  localparam int TIMEOUT_BIT = 5;
  localparam int TOGGLE_BIT = 6;
  localparam int POLL_BIT = 7;
  // bus timing, ns, and cycles at 125 MHz
  localparam int CLK_NS = 8;
  localparam int T_SETUP_NS = 30;
  localparam int T_PULSE_NS = 40;
  localparam int T_READ_NS = 70;
  localparam int SETUP_CYC = (T_SETUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int PULSE_CYC = (T_PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int READ_CYC = (T_READ_NS + CLK_NS - 1) / CLK_NS;
  // operation codes on the user port
  typedef enum logic [3:0] {
    NFCS_OP_READ, NFCS_OP_RESET, NFCS_OP_IDENT, NFCS_OP_PROGRAM,
    NFCS_OP_CHIP_ERASE, NFCS_OP_SECTOR_ERASE, NFCS_OP_SUSPEND,
    NFCS_OP_RESUME, NFCS_OP_FAST_ENTER, NFCS_OP_FAST_PROGRAM,
    NFCS_OP_FAST_EXIT, NFCS_OP_WRITE_RAW
  } nfcs_op_t;
endpackage

// [sim/nfcs_flash_model.sv]
// Purpose: behavioural flash device facing the host controller
// Assumes: program and erase finish at once, no busy time
// Notes: id values are arbitrary; deselected bus shows inverted data
`timescale 1ns/1ps
module nfcs_flash_model
  import nfcs_pkg::*;
#(
  parameter logic [15:0] MAKER_ID = 16'h005A, // arbitrary value
  parameter logic [15:0] DEVICE_ID = 16'h3C96 // arbitrary value
) (
  input wire logic [19:0] addr, // address pins
  input wire logic [15:0] dqOut, // host data drive
  input wire logic dqOe, // host drives data
  input wire logic ceN, // chip select
  input wire logic weN, // write strobe
  input wire logic oeN, // output strobe
  input wire logic byteN, // width select
  output logic [15:0] dqIn // data seen by host
);
  logic [15:0] mem [int];
  logic [15:0] v;
  int step = 0;
  int wr = 0;
  bit ident = 0;
  bit fast = 0; // off at power-up
  bit tmo = 0; // program hit a cleared bit, status shown until reset
  function automatic logic [15:0] rd(int a);
    return mem.exists(a) ? mem[a] : 16'hFFFF;
  endfunction
  // read path; inverted when idle so a stale value never passes
  always @(addr or ceN or oeN or byteN or ident or wr or tmo) begin
    v = ident ? (addr[1:0] == 2'b00 ? MAKER_ID : DEVICE_ID) : rd(addr);
    if (tmo) v = 16'(1 << TIMEOUT_BIT);
    dqIn = (!ceN && !oeN) ? (byteN ? v : {~v[15:8], v[7:0]}) : ~v;
  end
  // decode at the closing strobe; address is held through the pulse
  always @(posedge weN) begin
    logic [7:0] d;
    logic [19:0] u1, u2;
    if (ceN === 1'b0 && dqOe === 1'b1) begin
      d = dqOut[7:0];
      u1 = byteN ? UNLOCK1_WORD : UNLOCK1_BYTE;
      u2 = byteN ? UNLOCK2_WORD : UNLOCK2_BYTE;
      wr++;
      if (d == CMD_RESET && step != 3 && step != 10) begin
        step = 0;
        ident = 0;
        tmo = 0;
      end else case (step)
        // erase ends at once, so suspend and resume fall back to idle
        0, 5: begin
          if (fast && step == 0 && d == CMD_PROGRAM) step = 10;
          else if (fast && step == 0 && d == CMD_FAST_EXIT1) step = 11;
          else step = (addr == u1 && d == DATA_UNLOCK1) ? step + 1 : 0;
        end
        1, 6: step = (addr == u2 && d == DATA_UNLOCK2) ? step + 1 : 0;
        2: begin
          step = 0;
          if (addr == u1 && d == CMD_PROGRAM) step = 3;
          if (addr == u1 && d == CMD_ERASE_SETUP) step = 5;
          if (addr == u1 && d == CMD_IDENT) ident = 1;
          if (addr == u1 && d == CMD_FAST_ENTER) fast = 1;
        end
        3, 10: begin
          tmo = |(~rd(addr) & dqOut & (byteN ? 16'hFFFF : 16'h00FF));
          mem[addr] = rd(addr) & (byteN ? dqOut : {8'hFF, dqOut[7:0]});
          step = 0;
        end
        7: begin
          if (addr == u1 && d == CMD_CHIP_ERASE) mem.delete();
          if (d == CMD_SECTOR_ERASE) begin
            foreach (mem[k]) if (k[19:12] == addr[19:12]) mem[k] = 16'hFFFF;
          end
          step = 0;
        end
        11: begin
          if (d == CMD_FAST_EXIT2) fast = 0;
          step = 0;
        end
        default: step = 0;
      endcase
    end
  end
endmodule

// [sim/testbench.sv]
// Purpose: self-checking bench for the flash host controller
// Assumes: power-up lockout shortened to 10 cycles
// Notes: expected array is kept here; random data from a fixed seed
`timescale 1ns/1ps
`define CHK(nm, e, s) begin compares++; if ((s) !== (e)) begin num_errors++; \
  $display("[FAIL] %s exp %h got %h", nm, e, s); end end
module testbench
  import nfcs_pkg::*;
;
  localparam logic [15:0] MK = 16'h005A; // arbitrary id
  localparam logic [15:0] DV = 16'h3C96; // arbitrary id
  logic mclk = 0, rst = 1, reqValid = 0, byteMode = 0;
  nfcs_op_t reqOp = NFCS_OP_READ;
  logic [19:0] reqAddr = 20'h0, flashAddr, a;
  logic [15:0] reqData = 16'h0, rspData, flashDqOut, flashDqIn, q, d;
  logic reqReady, rspValid, flashDqOe, flashCeN, flashWeN, flashOeN, flashByteN;
  logic [15:0] expm [int];
  int num_errors = 0, compares = 0;
  bit t; // program expected to run into the timeout flag
  nfcs_host #(.POWERUP_CYC(10)) nfcs_host_i (.mclk, .rst, .reqValid, .reqOp, .reqAddr,
    .reqData, .byteMode, .reqReady, .rspValid, .rspData, .flashAddr, .flashDqOut,
    .flashDqOe, .flashDqIn, .flashCeN, .flashWeN, .flashOeN, .flashByteN);
  nfcs_flash_model #(.MAKER_ID(MK), .DEVICE_ID(DV)) nfcs_flash_model_i (.addr(flashAddr),
    .dqOut(flashDqOut), .dqOe(flashDqOe), .ceN(flashCeN), .weN(flashWeN),
    .oeN(flashOeN), .byteN(flashByteN), .dqIn(flashDqIn));
  always #4 mclk = ~mclk;
  function automatic logic [15:0] ex(logic [19:0] ad);
    return expm.exists(ad) ? expm[ad] : 16'hFFFF;
  endfunction
  // one request, bounded waits; inputs move on falling edges only
  task automatic op(input nfcs_op_t o, input logic [19:0] ad, input logic [15:0] dt);
    int n = 0;
    @(negedge mclk);
    while (reqReady !== 1'b1 && n < 100) begin @(negedge mclk); n++; end
    reqValid = 1'b1;
    reqOp = o;
    reqAddr = ad;
    reqData = dt;
    @(negedge mclk);
    reqValid = 1'b0;
    n = 0;
    while (rspValid !== 1'b1 && n < 300) begin @(negedge mclk); n++; end
    if (n >= 300) `CHK("rspValid", 1'b1, rspValid)
    q = rspData;
  endtask
  task automatic raw(input logic [19:0] ad, input logic [7:0] b);
    op(NFCS_OP_WRITE_RAW, ad, {8'h00, b});
  endtask
  task automatic chk_rd(input logic [19:0] ad, input logic [15:0] e);
    op(NFCS_OP_READ, ad, 16'h0);
    `CHK("read", e, q)
  endtask
  task automatic results();
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // watchdog well beyond the expected run of some 2400 cycles
  initial begin
    #400000;
    num_errors++;
    results();
  end
  initial begin
    void'($urandom(78));
    repeat (6) @(posedge mclk);
    @(negedge mclk);
    rst = 1'b0;
    `CHK("lockout", 1'b0, reqReady)
    for (int i = 0; i < 6; i++) begin
      a = 20'($urandom());
      d = 16'($urandom());
      op(NFCS_OP_PROGRAM, a, d);
      expm[a] = ex(a) & d;
      d = 16'($urandom());
      t = |(d & ~ex(a)); // a bit already at zero cannot return to one
      op(NFCS_OP_PROGRAM, a, d);
      expm[a] = ex(a) & d;
      if (t) begin
        op(NFCS_OP_READ, a, 16'h0);
        `CHK("timeout", 1'b1, q[TIMEOUT_BIT])
        op(NFCS_OP_RESET, 20'h0, 16'h0);
      end
      chk_rd(a, ex(a));
    end
    // aborted programs: reset between cycles, wrong address, wrong code
    a = 20'h40010;
    for (int j = 0; j < 3; j++) begin
      raw(UNLOCK1_WORD, DATA_UNLOCK1);
      raw(j == 1 ? 20'h00123 : UNLOCK2_WORD, DATA_UNLOCK2);
      if (j == 0) op(NFCS_OP_RESET, 20'h12345, 16'h0);
      raw(UNLOCK1_WORD, j == 2 ? 8'h77 : CMD_PROGRAM);
      raw(a, 8'h00);
      chk_rd(a, ex(a));
    end
    op(NFCS_OP_IDENT, 20'h0, 16'h0);
    for (int j = 0; j < 4; j++) chk_rd(20'(j & 1), (j & 1) ? DV : MK);
    op(NFCS_OP_RESET, 20'h0, 16'h0);
    chk_rd(20'h0, ex(20'h0));
    op(NFCS_OP_FAST_ENTER, 20'h0, 16'h0);
    for (int j = 0; j < 3; j++) begin
      a = 20'h20000 + 20'(j);
      d = 16'($urandom());
      op(NFCS_OP_FAST_PROGRAM, a, d);
      expm[a] = ex(a) & d;
      chk_rd(a, ex(a));
    end
    op(NFCS_OP_FAST_EXIT, 20'h0, 16'h0);
    raw(20'h0, CMD_PROGRAM);
    raw(a + 20'h1, 8'h00);
    chk_rd(a + 20'h1, ex(a + 20'h1));
    op(NFCS_OP_SUSPEND, 20'h0, 16'h0);
    op(NFCS_OP_RESUME, 20'h0, 16'h0);
    op(NFCS_OP_RESUME, 20'h0, 16'h0);
    chk_rd(a, ex(a));
    op(NFCS_OP_SECTOR_ERASE, 20'h20ABC, 16'h0);
    foreach (expm[k]) if (k[19:12] == 8'h20) expm[k] = 16'hFFFF;
    foreach (expm[k]) chk_rd(20'(k), ex(20'(k)));
    op(NFCS_OP_CHIP_ERASE, 20'h0, 16'h0);
    foreach (expm[k]) chk_rd(20'(k), 16'hFFFF);
    `CHK("byteN", 1'b1, flashByteN)
    byteMode = 1'b1;
    op(NFCS_OP_IDENT, 20'h0, 16'h0);
    `CHK("byteN", 1'b0, flashByteN)
    op(NFCS_OP_READ, 20'h0, 16'h0);
    `CHK("byteId", MK[7:0], q[7:0])
    op(NFCS_OP_RESET, 20'h0, 16'h0);
    byteMode = 1'b0;
    results();
  end
endmodule
